//--- design/mris_top.sv
// reference source select, duty mapping and regulation mode front end
`timescale 1ns/1ps
module mris_top
  import mris_pkg::*;
#(
  parameter logic [ADC_W-1:0] STANDBY_ENTRY_LEVEL     = 12'h0a0,
  parameter logic [ADC_W-1:0] STANDBY_EXIT_LEVEL      = 12'h100,
  parameter logic [ADC_W-1:0] ANALOG_FULL_SCALE_LEVEL = 12'hf00,
  parameter logic [CNT_W-1:0] FREQ_WINDOW_CYC         = 24'h030d40,
  parameter logic [CNT_W-1:0] FREQ_FULL_EDGES         = 24'h0003e8
) (
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_resetn,
  // configuration
  input  wire logic [1:0]        i_source_sel,
  input  wire logic [1:0]        i_reg_mode,
  // reference inputs
  input  wire logic              i_ref_pin,
  input  wire logic [ADC_W-1:0]  i_ref_adc,
  input  wire logic              i_ref_adc_valid,
  input  wire logic [DUTY_W-1:0] i_serial_cmd,
  // measured feedback, scaled to reference units
  input  wire logic [REF_W-1:0]  i_speed_fb,
  input  wire logic [REF_W-1:0]  i_power_fb,
  input  wire logic [REF_W-1:0]  i_quadrature_current_fb,
  // results
  output logic [DUTY_W-1:0]      o_duty_cmd,
  output logic [REF_W-1:0]       o_speed_ref,
  output logic [REF_W-1:0]       o_power_ref,
  output logic [REF_W-1:0]       o_current_ref,
  output logic [REF_W-1:0]       o_voltage_ref,
  output logic [REF_W-1:0]       o_ctrl_drive
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= i_ref_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end
  logic rise;
  assign rise = pin_sync_reg & ~pin_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // analog mapping, zero below exit level in both standby states
  mris_stby_e         stby_reg;
  logic [DUTY_W-1:0]  ana_duty_reg;
  logic [2*ADC_W-1:0] ana_prod;
  logic [DUTY_W-1:0]  ana_lin;
  localparam logic [ADC_W-1:0] ANA_SPAN = ANALOG_FULL_SCALE_LEVEL - STANDBY_EXIT_LEVEL;

  always_comb begin
    // interpolate exit level..full scale onto 0..full duty
    ana_prod = ((2*ADC_W)'(i_ref_adc) - (2*ADC_W)'(STANDBY_EXIT_LEVEL))
               * (2*ADC_W)'(DUTY_FULL);
    ana_lin  = DUTY_W'(ana_prod / (2*ADC_W)'(ANA_SPAN));
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      stby_reg <= MRIS_ZERO_ST;
    end else if (i_ref_adc_valid) begin
      unique case (stby_reg)
        MRIS_ZERO_ST:   if (i_ref_adc >= STANDBY_EXIT_LEVEL) stby_reg <= MRIS_ACTIVE_ST;
        MRIS_ACTIVE_ST: if (i_ref_adc <= STANDBY_ENTRY_LEVEL) stby_reg <= MRIS_ZERO_ST;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ana_duty_reg <= '0;
    end else if (i_ref_adc_valid) begin
      if (i_ref_adc <= STANDBY_ENTRY_LEVEL) begin
        ana_duty_reg <= '0;
      end else if (i_ref_adc > ANALOG_FULL_SCALE_LEVEL) begin
        ana_duty_reg <= DUTY_FULL;
      end else if (stby_reg == MRIS_ZERO_ST && i_ref_adc < STANDBY_EXIT_LEVEL) begin
        ana_duty_reg <= '0;
      end else if (i_ref_adc < STANDBY_EXIT_LEVEL) begin
        ana_duty_reg <= '0;
      end else begin
        ana_duty_reg <= ana_lin;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse duty measurement, high time over period
  logic [CNT_W-1:0]  per_cnt_reg;
  logic [CNT_W-1:0]  hi_cnt_reg;
  logic [DUTY_W-1:0] pwm_duty_reg;
  logic [CNT_W+DUTY_W-1:0] pwm_prod;
  logic [CNT_W+DUTY_W-1:0] pwm_q;
  always_comb begin
    pwm_prod = (CNT_W+DUTY_W)'(hi_cnt_reg) * (CNT_W+DUTY_W)'(DUTY_FULL);
    pwm_q    = pwm_prod / (CNT_W+DUTY_W)'(per_cnt_reg == '0 ? 24'h000001 : per_cnt_reg);
  end
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      per_cnt_reg  <= '0;
      hi_cnt_reg   <= '0;
      pwm_duty_reg <= '0;
    end else if (rise) begin
      // saturate against rounding above full duty
      pwm_duty_reg <= (pwm_q > (CNT_W+DUTY_W)'(DUTY_FULL)) ? DUTY_FULL
                      : pwm_q[DUTY_W-1:0];
      per_cnt_reg  <= 24'h000001;
      hi_cnt_reg   <= 24'h000001;
    end else if (per_cnt_reg == '1) begin
      // pin stuck: steady level means 0% or 100%
      pwm_duty_reg <= pin_sync_reg ? DUTY_FULL : '0;
    end else begin
      per_cnt_reg <= per_cnt_reg + 24'h000001;
      hi_cnt_reg  <= hi_cnt_reg + {23'h000000, pin_sync_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frequency measurement, rising edges per fixed window
  logic [CNT_W-1:0]  win_cnt_reg;
  logic [CNT_W-1:0]  edge_cnt_reg;
  logic [DUTY_W-1:0] freq_duty_reg;
  logic [CNT_W+DUTY_W-1:0] freq_q;
  assign freq_q = ((CNT_W+DUTY_W)'(edge_cnt_reg) * (CNT_W+DUTY_W)'(DUTY_FULL))
                  / (CNT_W+DUTY_W)'(FREQ_FULL_EDGES);
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      win_cnt_reg   <= '0;
      edge_cnt_reg  <= '0;
      freq_duty_reg <= '0;
    end else if (win_cnt_reg >= FREQ_WINDOW_CYC - 24'h000001) begin
      win_cnt_reg   <= '0;
      edge_cnt_reg  <= '0;
      // above maximum frequency clamps to full
      freq_duty_reg <= (edge_cnt_reg >= FREQ_FULL_EDGES) ? DUTY_FULL
                       : freq_q[DUTY_W-1:0];
    end else begin
      win_cnt_reg  <= win_cnt_reg + 24'h000001;
      edge_cnt_reg <= edge_cnt_reg + {23'h000000, rise};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source select into the common path
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_duty_cmd <= '0;
    end else begin
      unique case (i_source_sel)
        SRC_ANALOG: o_duty_cmd <= ana_duty_reg;
        SRC_PWM:    o_duty_cmd <= pwm_duty_reg;
        SRC_SERIAL: o_duty_cmd <= i_serial_cmd;
        SRC_FREQ:   o_duty_cmd <= freq_duty_reg;
      endcase
    end
  end

  logic [REF_W-1:0] ref_x;
  assign ref_x = o_duty_cmd[DUTY_W-1 -: REF_W];

  ////////////////////////////////////////////////////////////////////////////
  // one reference per regulation mode
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_speed_ref   <= '0;
      o_power_ref   <= '0;
      o_current_ref <= '0;
      o_voltage_ref <= '0;
    end else begin
      o_speed_ref   <= (i_reg_mode == MODE_SPEED)   ? ref_x : '0;
      o_power_ref   <= (i_reg_mode == MODE_POWER)   ? ref_x : '0;
      o_current_ref <= (i_reg_mode == MODE_CURRENT) ? ref_x : '0;
      o_voltage_ref <= (i_reg_mode == MODE_VOLTAGE) ? ref_x : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // regulation loop
  logic [15:0] tick_cnt_reg;
  logic        tick;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end
  assign tick = (tick_cnt_reg == 16'(PI_PERIOD_CYC - 1));

  mris_pi_if pi_bus ();
  assign pi_bus.tick   = tick;
  assign pi_bus.enable = (i_reg_mode != MODE_VOLTAGE);
  always_comb begin
    pi_bus.setpoint = ref_x;
    unique case (i_reg_mode)
      MODE_SPEED:   pi_bus.feedback = i_speed_fb;
      MODE_POWER:   pi_bus.feedback = i_power_fb;
      MODE_CURRENT: pi_bus.feedback = i_quadrature_current_fb;
      MODE_VOLTAGE: pi_bus.feedback = '0;
    endcase
  end

  mris_pi u_pi (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .pi       (pi_bus.loop)
  );

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ctrl_drive <= '0;
    end else if (i_reg_mode == MODE_VOLTAGE) begin
      o_ctrl_drive <= ref_x;
    end else begin
      o_ctrl_drive <= pi_bus.drive;
    end
  end
endmodule // mris_top

//--- design/mris_pkg.sv
// constants and types for the motor reference input select block
package mris_pkg;
  localparam int unsigned ADC_W  = 12;
  localparam int unsigned DUTY_W = 12;
  localparam int unsigned REF_W  = 8;
  localparam int unsigned CNT_W  = 24;

  localparam logic [DUTY_W-1:0] DUTY_FULL = 12'hfff;
  localparam logic [REF_W-1:0]  REF_FULL  = 8'hff;

  // source selector codes
  localparam logic [1:0] SRC_ANALOG = 2'h0;
  localparam logic [1:0] SRC_PWM    = 2'h1;
  localparam logic [1:0] SRC_SERIAL = 2'h2;
  localparam logic [1:0] SRC_FREQ   = 2'h3;

  // regulation mode codes
  localparam logic [1:0] MODE_SPEED   = 2'h0;
  localparam logic [1:0] MODE_POWER   = 2'h1;
  localparam logic [1:0] MODE_CURRENT = 2'h2;
  localparam logic [1:0] MODE_VOLTAGE = 2'h3;

  // pi loop gains as right shifts and update period
  localparam int unsigned KP_SHIFT       = 2;
  localparam int unsigned KI_SHIFT       = 6;
  localparam int unsigned PI_PERIOD_NS   = 10000;
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned PI_PERIOD_CYC  = PI_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned PI_W           = 20;

  typedef enum logic [1:0] {
    MRIS_ZERO_ST   = 2'b01,
    MRIS_ACTIVE_ST = 2'b10
  } mris_stby_e;
endpackage : mris_pkg

//--- design/mris_pi_if.sv
// request and answer of one pi regulation loop
`timescale 1ns/1ps
interface mris_pi_if;
  import mris_pkg::*;
  logic             tick;
  logic             enable;
  logic [REF_W-1:0] setpoint;
  logic [REF_W-1:0] feedback;
  logic [REF_W-1:0] drive;
  modport ctrl (output tick, output enable, output setpoint, output feedback, input drive);
  modport loop (input tick, input enable, input setpoint, input feedback, output drive);
endinterface : mris_pi_if

//--- design/mris_pi.sv
// proportional-integral regulator with saturated output
`timescale 1ns/1ps
module mris_pi
  import mris_pkg::*;
(
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  // loop port
  mris_pi_if.loop   pi
);
  logic signed [PI_W-1:0] integ_reg;
  logic signed [PI_W-1:0] err;
  logic signed [PI_W-1:0] integ_next;
  logic signed [PI_W-1:0] sum;

  always_comb begin
    err        = PI_W'($signed({1'b0, pi.setpoint})) - PI_W'($signed({1'b0, pi.feedback}));
    integ_next = integ_reg + (err >>> KI_SHIFT);
    // anti-windup: integral kept inside output range
    if (integ_next < 0) begin
      integ_next = '0;
    end else if (integ_next > PI_W'($signed({1'b0, REF_FULL}))) begin
      integ_next = PI_W'($signed({1'b0, REF_FULL}));
    end
    sum = integ_reg + (err >>> KP_SHIFT);
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      integ_reg <= '0;
    end else if (!pi.enable) begin
      integ_reg <= '0;
    end else if (pi.tick) begin
      integ_reg <= integ_next;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pi.drive <= '0;
    end else if (!pi.enable) begin
      pi.drive <= '0;
    end else if (pi.tick) begin
      if (sum < 0) begin
        pi.drive <= '0;
      end else if (sum > PI_W'($signed({1'b0, REF_FULL}))) begin
        pi.drive <= REF_FULL;
      end else begin
        pi.drive <= sum[REF_W-1:0];
      end
    end
  end
endmodule // mris_pi

//--- tb/mris_top_monitor.sv
// port assertions for the reference select block
`timescale 1ns/1ps
module mris_top_monitor
  import mris_pkg::*;
#(
  parameter logic [ADC_W-1:0] STANDBY_EXIT_LEVEL      = 12'h100,
  parameter logic [ADC_W-1:0] ANALOG_FULL_SCALE_LEVEL = 12'hf00
) (
  // clock and reset
  input wire logic              i_mclk,
  input wire logic              i_resetn,
  // inputs
  input wire logic [1:0]        i_source_sel,
  input wire logic [1:0]        i_reg_mode,
  input wire logic [ADC_W-1:0]  i_ref_adc,
  input wire logic              i_ref_adc_valid,
  input wire logic [DUTY_W-1:0] i_serial_cmd,
  // outputs
  input wire logic [DUTY_W-1:0] o_duty_cmd,
  input wire logic [REF_W-1:0]  o_speed_ref,
  input wire logic [REF_W-1:0]  o_voltage_ref,
  input wire logic [REF_W-1:0]  o_ctrl_drive
);
  localparam int EX = STANDBY_EXIT_LEVEL;
  localparam int FS = ANALOG_FULL_SCALE_LEVEL;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  function automatic logic [11:0] lin(input logic [11:0] a);
    return 12'((int'(a) - EX) * 4095 / (FS - EX));
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // analog sample needs the selector held over both pipeline stages
  chk_ana_clamp: assert property (
    (i_source_sel == SRC_ANALOG && i_ref_adc_valid && i_ref_adc > FS) ##1
    i_source_sel == SRC_ANALOG |=> o_duty_cmd == DUTY_FULL) else $error("analog clamp wrong");
  chk_ana_zero: assert property (
    (i_source_sel == SRC_ANALOG && i_ref_adc_valid && i_ref_adc < EX) ##1
    i_source_sel == SRC_ANALOG |=> o_duty_cmd == 12'h000) else $error("analog zero wrong");
  chk_ana_linear: assert property (
    (i_source_sel == SRC_ANALOG && i_ref_adc_valid && i_ref_adc >= EX && i_ref_adc <= FS) ##1
    i_source_sel == SRC_ANALOG |=> o_duty_cmd == lin($past(i_ref_adc, 2)))
    else $error("analog ramp wrong");
  chk_ana_hold: assert property (
    (i_source_sel == SRC_ANALOG && !i_ref_adc_valid) [*4] |-> $stable(o_duty_cmd))
    else $error("analog duty moved without sample");
  chk_serial_duty: assert property (
    i_source_sel == SRC_SERIAL |=> o_duty_cmd == $past(i_serial_cmd))
    else $error("serial duty wrong");
  chk_speed_ref: assert property (
    1'b1 |=> o_speed_ref == ($past(i_reg_mode) == MODE_SPEED ? $past(o_duty_cmd[11:4]) : 8'h00))
    else $error("speed reference wrong");
  chk_volt_ref: assert property (
    1'b1 |=> o_voltage_ref == ($past(i_reg_mode) == MODE_VOLTAGE ? $past(o_duty_cmd[11:4]) : 8'h00))
    else $error("voltage reference wrong");
  chk_volt_drive: assert property (
    (i_reg_mode == MODE_VOLTAGE && $stable(o_duty_cmd)) [*4] |-> o_ctrl_drive == o_voltage_ref)
    else $error("voltage drive not open loop");
  cover property (i_source_sel == SRC_FREQ && o_duty_cmd == DUTY_FULL);
  cover property (i_source_sel == SRC_PWM && o_duty_cmd != 12'h000);
  cover property (i_reg_mode == MODE_SPEED && o_ctrl_drive != 8'h00);
endmodule // mris_top_monitor

bind mris_top mris_top_monitor #(
  .STANDBY_EXIT_LEVEL(STANDBY_EXIT_LEVEL), .ANALOG_FULL_SCALE_LEVEL(ANALOG_FULL_SCALE_LEVEL)
) mris_top_monitor_inst (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_source_sel(i_source_sel), .i_reg_mode(i_reg_mode),
  .i_ref_adc(i_ref_adc), .i_ref_adc_valid(i_ref_adc_valid), .i_serial_cmd(i_serial_cmd),
  .o_duty_cmd(o_duty_cmd), .o_speed_ref(o_speed_ref), .o_voltage_ref(o_voltage_ref),
  .o_ctrl_drive(o_ctrl_drive)
);

//--- tb/mris_ref_model.sv
// external reference source: analog sampler and pulse train on the pin
`timescale 1ns/1ps
module mris_ref_model
  import mris_pkg::*;
(
  // clock and pulse shape, period zero holds the pin low
  input  wire logic             i_mclk,
  input  wire logic [7:0]       i_period,
  input  wire logic [7:0]       i_high,
  // to the block
  output logic                  o_ref_pin,
  output logic [ADC_W-1:0]      o_ref_adc,
  output logic                  o_ref_adc_valid
);
  logic [7:0] phase_reg = 8'h00;
  initial begin
    o_ref_adc = 12'h000;
    o_ref_adc_valid = 1'b0;
  end
  always @(posedge i_mclk) begin
    phase_reg <= (phase_reg + 8'h01 >= i_period) ? 8'h00 : phase_reg + 8'h01;
    o_ref_pin <= (i_period != 8'h00) && (phase_reg < i_high);
  end
  // level inverted once unqualified so a stale value never looks valid
  task automatic sample(input logic [ADC_W-1:0] level);
    @(posedge i_mclk);
    o_ref_adc <= level;
    o_ref_adc_valid <= 1'b1;
    @(posedge i_mclk);
    o_ref_adc <= ~level;
    o_ref_adc_valid <= 1'b0;
  endtask
endmodule // mris_ref_model

//--- tb/mris_top_tb.sv
// self-checking bench for the reference select block
`timescale 1ns/1ps
module mris_top_tb;
  import mris_pkg::*;
  localparam logic [11:0] EN = 12'h0a0, EX = 12'h100, FS = 12'hf00;
  logic i_mclk, i_resetn, ref_pin, adc_valid;
  logic [1:0] i_source_sel, i_reg_mode;
  logic [11:0] adc, i_serial_cmd, o_duty_cmd;
  logic [7:0] fb [3];
  logic [7:0] period, high, o_speed_ref, o_power_ref, o_current_ref, o_voltage_ref, o_ctrl_drive;
  logic [11:0] corner [8] = '{EN, EN + 12'h1, EX - 12'h1, EX, FS, FS + 12'h1, 12'h000, 12'hfff};
  int mismatches, comparisons;
  mris_top #(.STANDBY_ENTRY_LEVEL(EN), .STANDBY_EXIT_LEVEL(EX), .ANALOG_FULL_SCALE_LEVEL(FS),
    .FREQ_WINDOW_CYC(24'h0003e8), .FREQ_FULL_EDGES(24'h00000a)) mris_top_inst (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_source_sel(i_source_sel), .i_reg_mode(i_reg_mode),
    .i_ref_pin(ref_pin), .i_ref_adc(adc), .i_ref_adc_valid(adc_valid),
    .i_serial_cmd(i_serial_cmd), .i_speed_fb(fb[0]), .i_power_fb(fb[1]),
    .i_quadrature_current_fb(fb[2]), .o_duty_cmd(o_duty_cmd), .o_speed_ref(o_speed_ref),
    .o_power_ref(o_power_ref), .o_current_ref(o_current_ref), .o_voltage_ref(o_voltage_ref),
    .o_ctrl_drive(o_ctrl_drive));
  mris_ref_model mris_ref_model_inst (.i_mclk(i_mclk), .i_period(period), .i_high(high),
    .o_ref_pin(ref_pin), .o_ref_adc(adc), .o_ref_adc_valid(adc_valid));
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic check_refs(input logic [11:0] d);
    logic [7:0] r [4];
    r = '{o_speed_ref, o_power_ref, o_current_ref, o_voltage_ref};
    for (int m = 0; m < 4; m++) check("ref", {4'h0, r[m]}, (i_reg_mode == m) ? d >> 4 : 12'h000);
  endtask
  // linear region starts at exit level, so the hysteresis band reads zero
  function automatic logic [11:0] ana_exp(input logic [11:0] a);
    if (a < EX) return 12'h000;
    if (a > FS) return 12'hfff;
    return 12'((int'(a) - int'(EX)) * 4095 / (int'(FS) - int'(EX)));
  endfunction
  task automatic summarize;
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #(40000 * 5);
    mismatches++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [11:0] v;
    i_resetn = 1'b0;
    {i_source_sel, i_reg_mode, i_serial_cmd, period, high} = '0;
    fb = '{8'h00, 8'h00, 8'h00};
    void'($urandom(8));
    repeat (10) @(posedge i_mclk);
    i_resetn <= 1'b1;
    for (int k = 0; k < 28; k++) begin
      v = (k < 8) ? corner[k] : 12'($urandom);
      @(posedge i_mclk);
      i_reg_mode <= 2'($urandom);
      mris_ref_model_inst.sample(v);
      repeat (2) @(posedge i_mclk);
      #1 check("analog duty", o_duty_cmd, ana_exp(v));
      @(posedge i_mclk);
      #1 check_refs(ana_exp(v));
    end
    @(posedge i_mclk);
    i_source_sel <= SRC_SERIAL;
    for (int k = 0; k < 10; k++) begin
      v = (k == 0) ? 12'hfff : (k == 1) ? 12'h000 : 12'($urandom);
      @(posedge i_mclk);
      i_serial_cmd <= v;
      i_reg_mode <= 2'($urandom);
      @(posedge i_mclk);
      #1 check("serial duty", o_duty_cmd, v);
      @(posedge i_mclk);
      #1 check_refs(v);
    end
    @(posedge i_mclk);
    i_serial_cmd <= 12'h800;
    i_reg_mode <= MODE_VOLTAGE;
    repeat (10) @(posedge i_mclk);
    #1 check("voltage drive", {4'h0, o_ctrl_drive}, 12'h080);
    // only the fed-back quantity of the mode is low, so a wrong pick stalls
    for (int m = 0; m < 3; m++) begin
      @(posedge i_mclk);
      i_reg_mode <= MODE_VOLTAGE;
      repeat (10) @(posedge i_mclk);
      i_reg_mode <= 2'(m);
      for (int f = 0; f < 3; f++) fb[f] <= (f == m) ? 8'h00 : 8'hff;
      repeat (4100) @(posedge i_mclk);
      #1 check("pi drive", {11'h000, o_ctrl_drive != 8'h00}, 12'h001);
    end
    @(posedge i_mclk);
    i_source_sel <= SRC_FREQ;
    period <= 8'h04;
    high <= 8'h02;
    repeat (2100) @(posedge i_mclk);
    #1 check("freq clamp", o_duty_cmd, 12'hfff);
    @(posedge i_mclk);
    period <= 8'h00;
    repeat (2100) @(posedge i_mclk);
    #1 check("freq zero", o_duty_cmd, 12'h000);
    @(posedge i_mclk);
    i_source_sel <= SRC_PWM;
    period <= 8'h14;
    high <= 8'h0a;
    repeat (200) @(posedge i_mclk);
    #1 check("pwm half", {11'h000, o_duty_cmd > 12'h7c0 && o_duty_cmd < 12'h840}, 12'h001);
    summarize();
  end
endmodule // mris_top_tb
